/* File: core/owrw_master.v */
// Purpose: single-wire bus master timing for reset/presence and write-zero slots
// Assumes: open-drain line, pull-up outside; 50 MHz sys_clk
// Notes: write-one and read slots are not provided
// Notes: requests that arrive while busy are dropped without a trace
// Notes: the counter width must hold the longest count of the chosen clock
`include "owrw_map.vh"
module owrw_master #(
	parameter CLK_MHZ = `OWRW_CLK_MHZ,
	parameter RST_LOW_US = `OWRW_RST_LOW_US,
	parameter RECOVERY_US = `OWRW_RECOVERY_US
) (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Commands, one-cycle pulses, taken only while idle
	input wire reset_req,
	input wire zero_req,
	// Status
	output reg busy,
	output reg done,
	output reg presence_detected,
	// Open-drain line
	input wire line_in,
	output reg line_out,
	output reg line_oe
);
	// Durations are worked out at integer width first and then cut to the counter width
	// on purpose; the counter holds the longest nominal count at 50 MHz with room to spare
	localparam integer RST_LOW_INT = RST_LOW_US * CLK_MHZ;
	localparam integer RECOVERY_INT = RECOVERY_US * CLK_MHZ;
	localparam integer ZERO_LOW_INT = `OWRW_ZERO_LOW_US * CLK_MHZ;
	localparam integer SLOT_INT = `OWRW_SLOT_US * CLK_MHZ;
	localparam integer ZERO_REL_INT = SLOT_INT - ZERO_LOW_INT;
	// Presence window: earliest start to latest end of a slave's pulse
	localparam integer PRES_FROM_INT = `OWRW_PRES_WAIT_MIN_US * CLK_MHZ;
	localparam integer PRES_TO_INT =
		(`OWRW_PRES_WAIT_MAX_US + `OWRW_PRES_LOW_MAX_US) * CLK_MHZ;
	localparam [`OWRW_CNT_W-1:0] RST_LOW_CYC = RST_LOW_INT[`OWRW_CNT_W-1:0];
	localparam [`OWRW_CNT_W-1:0] RECOVERY_CYC = RECOVERY_INT[`OWRW_CNT_W-1:0];
	localparam [`OWRW_CNT_W-1:0] ZERO_LOW_CYC = ZERO_LOW_INT[`OWRW_CNT_W-1:0];
	localparam [`OWRW_CNT_W-1:0] ZERO_REL_CYC = ZERO_REL_INT[`OWRW_CNT_W-1:0];
	localparam [`OWRW_CNT_W-1:0] PRES_FROM_CYC = PRES_FROM_INT[`OWRW_CNT_W-1:0];
	localparam [`OWRW_CNT_W-1:0] PRES_TO_CYC = PRES_TO_INT[`OWRW_CNT_W-1:0];
	localparam [`OWRW_CNT_W-1:0] CNT_ONE = {{(`OWRW_CNT_W-1){1'b0}}, 1'b1};
	localparam [`OWRW_CNT_W-1:0] CNT_ZERO = {`OWRW_CNT_W{1'b0}};
	// Loaded one short because the loading edge is already the first cycle of the phase
	localparam [`OWRW_CNT_W-1:0] RST_LOW_LOAD = RST_LOW_CYC - CNT_ONE;
	localparam [`OWRW_CNT_W-1:0] RECOVERY_LOAD = RECOVERY_CYC - CNT_ONE;
	localparam [`OWRW_CNT_W-1:0] ZERO_LOW_LOAD = ZERO_LOW_CYC - CNT_ONE;
	localparam [`OWRW_CNT_W-1:0] ZERO_REL_LOAD = ZERO_REL_CYC - CNT_ONE;

	// Synchronised line and request decode
	wire line_sync;
	wire line_low;
	wire is_idle;
	wire take_reset;
	wire take_zero;

	// Sequencer
	reg [2:0] state;
	reg [2:0] next_state;
	reg [`OWRW_CNT_W-1:0] count;
	reg [`OWRW_CNT_W-1:0] next_count;
	wire count_last;
	wire [`OWRW_CNT_W-1:0] count_dec;

	// Presence capture
	reg pres_seen;
	reg next_pres_seen;
	wire [`OWRW_CNT_W-1:0] elapsed;
	wire after_wait;
	wire before_end;
	wire in_window;

	// Next values of the registered outputs
	reg next_busy;
	reg next_done;
	reg next_presence;
	reg next_line_oe;

	owrw_sync u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async_in(line_in),
		.sync_out(line_sync)
	);

	assign line_low = !line_sync;

	// Requests are looked at only while idle, so a late pulse cannot stretch or cut a slot
	assign is_idle = (state == `OWRW_ST_IDLE);
	assign take_reset = is_idle && reset_req;
	// A reset request outranks a zero slot asked for in the same cycle
	assign take_zero = is_idle && !reset_req && zero_req;

	assign count_last = (count == CNT_ZERO);
	assign count_dec = count - CNT_ONE;

	// Cycles since release plus one; the two-cycle synchroniser lag is not taken off,
	// which moves the window early by 40 ns, far inside the slave's tolerance
	assign elapsed = RECOVERY_CYC - count;
	assign after_wait = (elapsed > PRES_FROM_CYC);
	assign before_end = (elapsed <= PRES_TO_CYC);
	assign in_window = (state == `OWRW_ST_RECOVER) && after_wait && before_end;

	// The counter runs down by itself; each state only decides what to load at its end
	always @* begin
		next_state = state;
		next_count = count;
		if (!count_last)
			next_count = count_dec;
		case (state)
		`OWRW_ST_IDLE: begin
			if (take_reset) begin
				next_state = `OWRW_ST_RST_LOW;
				next_count = RST_LOW_LOAD;
			end else if (take_zero) begin
				next_state = `OWRW_ST_ZERO_LOW;
				next_count = ZERO_LOW_LOAD;
			end
		end

		`OWRW_ST_RST_LOW: begin
			// Release and start timing the recovery on the same edge
			if (count_last) begin
				next_state = `OWRW_ST_RECOVER;
				next_count = RECOVERY_LOAD;
			end
		end

		`OWRW_ST_RECOVER: begin
			// No slot may start before the recovery count has run out
			if (count_last)
				next_state = `OWRW_ST_IDLE;
		end

		`OWRW_ST_ZERO_LOW: begin
			// Low time and slot length are both fixed, so both stay inside their limits
			if (count_last) begin
				next_state = `OWRW_ST_ZERO_REL;
				next_count = ZERO_REL_LOAD;
			end
		end

		`OWRW_ST_ZERO_REL: begin
			if (count_last)
				next_state = `OWRW_ST_IDLE;
		end

		default: begin
			next_state = `OWRW_ST_IDLE;
			next_count = CNT_ZERO;
		end
		endcase
	end

	// Presence is gathered over the whole window and cleared as each reset release begins
	always @* begin
		next_pres_seen = pres_seen;
		if (state == `OWRW_ST_RST_LOW && count_last)
			next_pres_seen = 1'b0;
		else if (in_window && line_low)
			next_pres_seen = 1'b1;
	end

	always @* begin
		next_busy = (next_state != `OWRW_ST_IDLE);
		next_done = !is_idle && (next_state == `OWRW_ST_IDLE);
		// Driven only while a low phase runs; release leaves the line to the pull-up
		next_line_oe = (next_state == `OWRW_ST_RST_LOW)
			|| (next_state == `OWRW_ST_ZERO_LOW);
		next_presence = presence_detected;
		// Flag updates once the recovery ends so the reader sees a settled answer
		if (state == `OWRW_ST_RECOVER && count_last)
			next_presence = next_pres_seen;
	end

	// Sequencer state; reset returns it to idle with the counter cleared
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= `OWRW_ST_IDLE;
			count <= CNT_ZERO;
			pres_seen <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			pres_seen <= next_pres_seen;
		end
	end

	// Every output comes straight from a flip-flop so pin timing does not hang on decode
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			presence_detected <= 1'b0;
			line_oe <= 1'b0;
		end else begin
			busy <= next_busy;
			done <= next_done;
			presence_detected <= next_presence;
			line_oe <= next_line_oe;
		end
	end

	// The line is only ever pulled low; the drive value sits high through reset
	always @(posedge sys_clk) begin
		if (sys_rst)
			line_out <= 1'b1;
		else
			line_out <= 1'b0;
	end
endmodule

/* File: core/owrw_map.vh */
// Purpose: timing constants for the single-wire master timing engine
// Assumes: 50 MHz system clock, 20 ns period
// Notes: times in microseconds, counts derived in cycles
`ifndef OWRW_MAP_VH
`define OWRW_MAP_VH
`define OWRW_CLK_MHZ 50
`define OWRW_RST_LOW_US 511
`define OWRW_RST_LOW_MIN_US 480
`define OWRW_RECOVERY_US 512
`define OWRW_RECOVERY_MIN_US 480
`define OWRW_PRES_WAIT_MIN_US 15
`define OWRW_PRES_WAIT_MAX_US 60
`define OWRW_PRES_LOW_MAX_US 240
`define OWRW_ZERO_LOW_US 100
`define OWRW_ZERO_LOW_MIN_US 60
`define OWRW_ZERO_LOW_MAX_US 120
`define OWRW_SLOT_US 117
`define OWRW_SLOT_MAX_US 120
`define OWRW_CNT_W 15
`define OWRW_ST_IDLE 3'h0
`define OWRW_ST_RST_LOW 3'h1
`define OWRW_ST_RECOVER 3'h2
`define OWRW_ST_ZERO_LOW 3'h3
`define OWRW_ST_ZERO_REL 3'h4
`endif

/* File: core/owrw_sync.v */
// Purpose: two flip-flop synchroniser for the line input
// Assumes: input is asynchronous to sys_clk
// Notes: resets to the idle (high) line level
module owrw_sync (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Data
	input wire async_in,
	output reg sync_out
);
	reg stage1;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			stage1 <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

/* File: verification/owrw_chk_assertions.sv */
// Purpose: master timing checks
// Assumes: one clock domain
// Notes: counters replace long repeats
module owrw_chk #(parameter CLK_MHZ = 50, RST_LOW_US = 511, RECOVERY_US = 512) (
	input wire sys_clk,
	input wire sys_rst,
	input wire reset_req,
	input wire zero_req,
	input wire busy,
	input wire done,
	input wire presence_detected,
	input wire line_oe
);
	localparam int RL = RST_LOW_US * CLK_MHZ, RC = RECOVERY_US * CLK_MHZ;
	localparam int ZL = 100 * CLK_MHZ, ZR = 17 * CLK_MHZ;
	int n = 0, m = 0;
	reg z = 0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	always @(posedge sys_clk) begin
		n <= line_oe ? n + 1 : 0;
		m <= busy && !line_oe ? m + 1 : 0;
		if (!busy) z <= !reset_req;
	end
	a_rst_low: assert property ($fell(line_oe) && !z |-> n == RL) else $error("low");
	a_rst_rec: assert property (done && !z |-> m == RC) else $error("recovery");
	a_zero_low: assert property ($fell(line_oe) && z |-> n == ZL) else $error("zero");
	a_zero_slot: assert property (done && z |-> m == ZR) else $error("slot");
	a_flag_hold: assert property (!done |-> $stable(presence_detected)) else $error("flag");
	sequence s_take;
		!busy && (reset_req || zero_req);
	endsequence
	sequence s_drive;
		busy && line_oe && !done;
	endsequence
	a_req_start: assert property (s_take |=> s_drive) else $error("no start");
	a_done_pulse: assert property (done |=> !done) else $error("long done");
endmodule
bind owrw_master owrw_chk #(.CLK_MHZ(CLK_MHZ), .RST_LOW_US(RST_LOW_US), .RECOVERY_US(RECOVERY_US))
	owrw_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_req(reset_req), .busy(busy),
	.zero_req(zero_req), .done(done), .presence_detected(presence_detected), .line_oe(line_oe));

/* File: verification/owrw_slave.sv */
// Purpose: slave model
// Assumes: pull-up on the line
// Notes: answers every release, bench gates it
module owrw_slave (
	input wire sys_clk,
	input wire line_oe,
	input wire present,
	output wire line_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 9999;
	always @(posedge sys_clk) cnt <= line_oe ? 0 : cnt + 1;
	// Waits 20 us, then pulls low 60 us
	assign line_in = !(line_oe || present && cnt >= 1000 && cnt < 4000);
endmodule

/* File: verification/test_one_wire_reset_write_timing.sv */
// Purpose: master bench
// Assumes: 50 MHz
// Notes: short reset timing
module test_one_wire_reset_write_timing;
	timeunit 1ns;
	timeprecision 1ns;
	reg sys_clk = 0, sys_rst = 1, reset_req = 0, zero_req = 0, present = 1;
	wire busy, done, presence_detected, line_in, line_out, line_oe;
	int fails = 0, checked = 0, cycles = 0;
	owrw_master #(.RST_LOW_US(2), .RECOVERY_US(100)) owrw_master_i (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reset_req(reset_req), .zero_req(zero_req), .busy(busy), .done(done),
		.presence_detected(presence_detected), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe));
	owrw_slave owrw_slave_i (.sys_clk(sys_clk), .line_oe(line_oe), .present(present),
		.line_in(line_in));
	initial forever #10 sys_clk = !sys_clk;
	always @(posedge sys_clk) if (cycles++ == 40000) begin
		fails++;
		end_sim;
	end
	task automatic chk(string nm, logic [15:0] e, s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %0d seen %0d", nm, e, s);
		end
	endtask
	task automatic end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// A reset request is thrown in mid-sequence; it must be ignored
	task automatic run(logic zr, logic [15:0] ec, ep);
		logic [15:0] c = 0;
		{reset_req, zero_req} = {!zr, zr};
		@(negedge sys_clk);
		{reset_req, zero_req} = 2'h0;
		chk("drive", 16'h1, line_oe);
		chk("busy", 16'h1, busy);
		chk("line_out", 16'h0, line_out);
		while (done !== 1'b1 && c < 16'h2000) begin
			@(negedge sys_clk);
			c++;
			if (c[15:1] == 15'h10) reset_req = !c[0];
		end
		chk("cycles", ec, c);
		chk("presence", ep, presence_detected);
		@(negedge sys_clk);
		chk("done_pulse", 16'h0, done);
		chk("idle", 16'h0, busy);
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		sys_rst = 0;
		run(0, 16'h13EC, 16'h1);
		present = 0;
		run(1, 16'h16DA, 16'h1);
		run(0, 16'h13EC, 16'h0);
		end_sim;
	end
endmodule
